// [shared/acm_pkg.sv]
`default_nettype none
package acm_pkg;
  // register byte offsets, one aligned word each
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_X        = 8'h08;
  localparam logic [7:0] OFF_Y        = 8'h0c;
  localparam logic [7:0] OFF_Z        = 8'h10;
  localparam logic [7:0] OFF_INT_MASK = 8'h14;
  localparam logic [7:0] OFF_INT_STAT = 8'h18;
  localparam logic [7:0] OFF_MOT_CTRL = 8'h1c;
  localparam logic [7:0] OFF_MOT_TH   = 8'h20;
  localparam logic [7:0] OFF_BUF_CTRL = 8'h24;
  localparam logic [7:0] OFF_BUF_CNT  = 8'h28;
  localparam logic [7:0] OFF_BUF_DATA = 8'h2c;
  localparam logic [7:0] OFF_TEMP     = 8'h30;
  localparam logic [7:0] OFF_FF_CFG   = 8'h34;
  // field positions
  localparam int unsigned BIT_CKERR    = 0;
  localparam int unsigned BIT_RUN      = 1;
  localparam int unsigned BIT_FF_EN    = 3;
  localparam int unsigned BIT_BUF_EN   = 0;
  localparam int unsigned BIT_BUF_TH   = 1;
  localparam int unsigned SRC_MOT      = 0;
  localparam int unsigned SRC_FF       = 1;
  localparam int unsigned SRC_BUF      = 2;
  localparam int unsigned POS_MOT_DIR  = 4;
  localparam int unsigned POS_MOT_REQ  = 3;
  localparam int unsigned POS_FF_TIME  = 8;
  // mode select codes
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [2:0] MODE_OPT1    = 3'h1;
  localparam logic [2:0] MODE_OPT2    = 3'h2;
  localparam logic [2:0] MODE_MOTION  = 3'h3;
  // reset values
  localparam logic       CKERR_RST    = 1'b1;
  localparam logic [7:0] FF_TH_RST    = 8'h08;
  localparam logic [7:0] FF_TIME_RST  = 8'h10;
  // signal path constants
  localparam logic [15:0] GAIN_RST    = 16'h1000;
  localparam int unsigned GAIN_SHIFT  = 12;
  localparam int unsigned SH_NORMAL   = 2;
  localparam int unsigned SH_NARROW   = 3;
  localparam int unsigned SH_WIDE     = 1;
  localparam int unsigned SH_MOTION   = 6;
  localparam logic [1:0]  NVM_CHECK   = 2'h3;
  typedef enum logic [1:0] {ST_LOAD, ST_CHECK, ST_RUN} acm_state_type;
endpackage
`default_nettype wire

// [hw/acm_ring_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module acm_ring_mem #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 64
) (
  input  wire logic                     hclk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output var  logic [WIDTH-1:0]         rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // read-before-write; independent pointers allow both in one cycle
  always_ff @(posedge hclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// [hw/acm_core.sv]
// Overview of operation
// - active-low reset holds all logic
// - load nvm words, checksum clears error flag
// - normal mode after startup, axes readable
// - demux, filter, decimate, map, update outputs
// - motion mode freezes acceleration output registers
// - motion: per-axis thresholds, and/or, direction
// - free-fall runs beside measurement, raises interrupt
// - interrupt pin, maskable sources, readable status
// - fifo of 64 samples, oldest first
// - separate read and write pointers
// - full buffer overwrites oldest sample
// - interrupt at half or three quarters
// - samples enter once per decimated output frame
// - whole buffer drained in one burst
// - nine-bit temperature readable
// - option 1 bypass or narrow, option 2 wide
// - bypass skips the low-pass filter
// - narrow filters harder, half output rate
// - wide band uses wider pass band
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module acm_core #(
  parameter int unsigned BUF_DEPTH  = 64,
  parameter int unsigned VARIANT    = 2,
  parameter bit          TEMP_EN    = 1'b1,
  parameter int unsigned DEC_NORMAL = 4
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output var  logic                hreadyout,
  output var  logic [31:0]         hrdata,
  output var  logic                hresp,
  input  wire logic                adc_valid,
  input  wire logic [1:0]          adc_chan,
  input  wire logic [15:0]         adc_data,
  input  wire logic [8:0]          temp_raw,
  output var  logic [1:0]          nvm_addr,
  input  wire logic [15:0]         nvm_rdata,
  output var  logic [15:0]         osc_trim,
  output var  logic                int_out
);
  import acm_pkg::*;

  localparam int unsigned PW = $clog2(BUF_DEPTH);
  localparam logic [PW:0] LVL_HALF = (PW+1)'(BUF_DEPTH / 2);
  localparam logic [PW:0] LVL_3Q   = (PW+1)'((BUF_DEPTH * 3) / 4);
  localparam logic [PW:0] LVL_FULL = (PW+1)'(BUF_DEPTH);
  localparam logic [4:0]  DEC_LIM  = 5'(DEC_NORMAL);

  typedef struct packed {
    acm_state_type    st;
    logic [1:0]       ld_idx;
    logic             ld_wait;
    logic [15:0]      sum;
    logic [15:0]      chk;
    logic [15:0]      gain;
    logic [15:0]      offs;
    logic [15:0]      trim;
    logic             ckerr;
    logic [2:0]       mode;
    logic             ffen;
    logic [2:0]       intmask;
    logic [2:0]       intsrc;
    logic [2:0]       mot_dir;
    logic [5:0]       mdctrl;
    logic [23:0]      mot_th;
    logic [2:0]       mot_hit;
    logic [7:0]       ff_th;
    logic [7:0]       ff_time;
    logic [7:0]       ff_cnt;
    logic             buf_en;
    logic             buf_th;
    logic [2:0][15:0] filt;
    logic [2:0][15:0] raw;
    logic [4:0]       dec_cnt;
    logic [2:0][15:0] acc;
    logic [PW-1:0]    wptr;
    logic [PW-1:0]    rptr;
    logic [PW:0]      cnt;
    logic [1:0]       axis;
    logic             dp_valid;
    logic             dp_write;
    logic [7:0]       dp_addr;
    logic             hready;
    logic [31:0]      hrdata;
    logic             irq;
  } acm_core_state_type;

  acm_core_state_type s_q;
  acm_core_state_type s_d;
  logic               mem_we;
  logic [47:0]        mem_wdata;
  logic [47:0]        mem_rdata;
  logic [15:0]        smp;
  logic [15:0]        dlt;
  logic [4:0]         lim;
  logic               frame;
  logic               trig;
  logic               still;
  logic [31:0]        rd;

  function automatic logic [15:0] abs16(input logic [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic [15:0] lowpass(input logic [15:0] y, input logic [15:0] x,
                                          input int unsigned sh);
    logic signed [16:0] e;
    e = 17'($signed(x)) - 17'($signed(y));
    return y + 16'(e >>> sh);
  endfunction

  function automatic logic [15:0] calib(input logic [15:0] v, input logic [15:0] o,
                                        input logic [15:0] g);
    logic signed [33:0] p;
    p = 34'($signed(v) - $signed(o)) * 34'($signed({1'b0, g}));
    return p[GAIN_SHIFT+15:GAIN_SHIFT];
  endfunction

  function automatic logic [7:0] abs8(input logic [7:0] v);
    return v[7] ? 8'(-v) : v;
  endfunction

  acm_ring_mem #(
    .WIDTH (48),
    .DEPTH (BUF_DEPTH)
  ) u_mem (
    .hclk  (hclk),
    .we    (mem_we),
    .waddr (s_q.wptr),
    .wdata (mem_wdata),
    .raddr (s_d.rptr),
    .rdata (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d       = s_q;
    mem_we    = 1'b0;
    mem_wdata = {s_d.acc[0], s_d.acc[1], s_d.acc[2]};
    smp       = adc_data;
    dlt       = 16'h0000;
    lim       = DEC_LIM;
    frame     = 1'b0;
    trig      = 1'b0;
    still     = 1'b1;
    rd        = 32'h0000_0000;

    // nvm words arrive one cycle after the address; each word takes two cycles
    case (s_q.st)
      ST_LOAD:
      begin
        s_d.ld_wait = ~s_q.ld_wait;
        if (s_q.ld_wait)
        begin
          case (s_q.ld_idx)
            2'h0:    s_d.gain = nvm_rdata;
            2'h1:    s_d.offs = nvm_rdata;
            2'h2:    s_d.trim = nvm_rdata;
            default: s_d.chk  = nvm_rdata;
          endcase
          if (s_q.ld_idx != NVM_CHECK)
          begin
            s_d.sum = s_q.sum + nvm_rdata;
          end
          if (s_q.ld_idx == NVM_CHECK)
          begin
            s_d.st = ST_CHECK;
          end
          s_d.ld_idx = s_q.ld_idx + 2'h1;
        end
      end
      ST_CHECK:
      begin
        s_d.ckerr = (s_q.sum != s_q.chk);
        s_d.mode = MODE_NORMAL;
        s_d.st   = ST_RUN;
      end
      ST_RUN:
      begin
        // option codes fall back to normal where the variant lacks them
        case (s_q.mode)
          MODE_OPT1:   lim = (VARIANT == 0) ? DEC_LIM : 5'(DEC_LIM << 1);
          default:     lim = DEC_LIM;
        endcase
        if (adc_valid && adc_chan != 2'h3)
        begin
          s_d.raw[adc_chan] = smp;
          if (s_q.mode == MODE_MOTION)
          begin
            // slow baseline gives the high-pass part of the motion filter
            dlt = abs16(smp - s_q.filt[adc_chan]);
            if (dlt > {4'h0, s_q.mot_th[adc_chan*8 +: 8], 4'h0})
            begin
              s_d.mot_hit[adc_chan] = 1'b1;
            end
            s_d.filt[adc_chan] = lowpass(s_q.filt[adc_chan], smp, SH_MOTION);
          end
          else if (s_q.mode == MODE_OPT1 && VARIANT != 0)
          begin
            s_d.filt[adc_chan] = lowpass(s_q.filt[adc_chan], smp, SH_NARROW);
          end
          else if (s_q.mode == MODE_OPT2 && VARIANT == 2)
          begin
            s_d.filt[adc_chan] = lowpass(s_q.filt[adc_chan], smp, SH_WIDE);
          end
          else if (s_q.mode == MODE_OPT1)
          begin
            s_d.filt[adc_chan] = smp;
          end
          else
          begin
            s_d.filt[adc_chan] = lowpass(s_q.filt[adc_chan], smp, SH_NORMAL);
          end
          if (adc_chan == 2'h2)
          begin
            s_d.dec_cnt = s_q.dec_cnt + 5'h01;
            if (s_q.dec_cnt >= lim - 5'h01)
            begin
              s_d.dec_cnt = 5'h00;
              frame       = 1'b1;
            end
          end
        end
      end
      default:
      begin
        s_d.st = ST_LOAD;
      end
    endcase

    if (frame && s_q.mode == MODE_MOTION)
    begin
      // and-terms must all fire; or-terms need any one when no and-term is set
      trig = ((s_d.mot_hit & s_q.mdctrl[5:3]) == s_q.mdctrl[5:3]) &&
             ((|(s_d.mot_hit & s_q.mdctrl[2:0])) || (|s_q.mdctrl[5:3]));
      if (trig)
      begin
        s_d.intsrc[SRC_MOT] = 1'b1;
        s_d.mot_dir         = s_d.mot_hit;
      end
      s_d.mot_hit = 3'h0;
    end
    else if (frame)
    begin
      // 45 degree element axes are folded onto orthogonal x and y
      s_d.acc[0] = calib(16'(($signed(s_d.filt[0]) - $signed(s_d.filt[1])) >>> 1),
                         s_q.offs, s_q.gain);
      s_d.acc[1] = calib(16'(($signed(s_d.filt[0]) + $signed(s_d.filt[1])) >>> 1),
                         s_q.offs, s_q.gain);
      s_d.acc[2] = calib(s_d.filt[2], s_q.offs, s_q.gain);
      for (int i = 0; i < 3; i++)
      begin
        if (abs8(s_d.acc[i][15:8]) >= s_q.ff_th)
        begin
          still = 1'b0;
        end
      end
      if (s_q.ffen && still)
      begin
        if (s_q.ff_cnt >= s_q.ff_time)
        begin
          s_d.intsrc[SRC_FF] = 1'b1;
        end
        else
        begin
          s_d.ff_cnt = s_q.ff_cnt + 8'h01;
        end
      end
      else
      begin
        s_d.ff_cnt = 8'h00;
      end
    end

    // bus: data phase of the transfer captured last cycle
    if (s_q.dp_valid && s_q.dp_write)
    begin
      s_d.dp_valid = 1'b0;
      case (s_q.dp_addr)
        OFF_MODE:
        begin
          s_d.mode = hwdata[2:0];
          s_d.ffen = hwdata[BIT_FF_EN];
        end
        OFF_INT_MASK: s_d.intmask = hwdata[2:0];
        OFF_MOT_CTRL: s_d.mdctrl  = hwdata[5:0];
        OFF_MOT_TH:   s_d.mot_th  = hwdata[23:0];
        OFF_BUF_CTRL:
        begin
          s_d.buf_en = hwdata[BIT_BUF_EN];
          s_d.buf_th = hwdata[BIT_BUF_TH];
        end
        OFF_FF_CFG:
        begin
          s_d.ff_th   = hwdata[7:0];
          s_d.ff_time = hwdata[POS_FF_TIME +: 8];
        end
        default: s_d.dp_valid = 1'b0;
      endcase
    end
    else if (s_q.dp_valid)
    begin
      case (s_q.dp_addr)
        OFF_STATUS:   rd = {30'h0, s_q.st == ST_RUN, s_q.ckerr};
        OFF_MODE:     rd = {28'h0, s_q.ffen, s_q.mode};
        OFF_X:        rd = {16'h0, s_q.acc[0]};
        OFF_Y:        rd = {16'h0, s_q.acc[1]};
        OFF_Z:        rd = {16'h0, s_q.acc[2]};
        OFF_INT_MASK: rd = {29'h0, s_q.intmask};
        OFF_INT_STAT: rd = {25'h0, s_q.mot_dir, 1'b0, s_q.intsrc};
        OFF_MOT_CTRL: rd = {26'h0, s_q.mdctrl};
        OFF_MOT_TH:   rd = {8'h0, s_q.mot_th};
        OFF_BUF_CTRL: rd = {30'h0, s_q.buf_th, s_q.buf_en};
        OFF_BUF_CNT:  rd = 32'(s_q.cnt);
        OFF_BUF_DATA:
        begin
          if (s_q.cnt != '0)
          begin
            rd = {16'h0, mem_rdata[(2 - s_q.axis)*16 +: 16]};
            s_d.axis = s_q.axis + 2'h1;
            if (s_q.axis == 2'h2)
            begin
              // pointer moves once per xyz triple, so bursts drain in order
              s_d.axis = 2'h0;
              s_d.rptr = s_q.rptr + 1'b1;
              s_d.cnt  = s_q.cnt - 1'b1;
            end
          end
        end
        OFF_TEMP:     rd = TEMP_EN ? {23'h0, temp_raw} : 32'h0000_0000;
        OFF_FF_CFG:   rd = {16'h0, s_q.ff_time, s_q.ff_th};
        default:      rd = 32'h0000_0000;
      endcase
      if (s_q.dp_addr == OFF_INT_STAT)
      begin
        // clear on read, but an event in this cycle survives
        s_d.intsrc[SRC_MOT] = s_d.intsrc[SRC_MOT] & ~s_q.intsrc[SRC_MOT];
        s_d.intsrc[SRC_FF]  = s_d.intsrc[SRC_FF] & ~s_q.intsrc[SRC_FF];
        s_d.intsrc[SRC_MOT] = s_d.intsrc[SRC_MOT] | (frame & trig);
        s_d.intsrc[SRC_FF] = s_d.intsrc[SRC_FF] |
                             (frame && s_q.mode != MODE_MOTION && s_q.ffen && still &&
                              s_q.ff_cnt >= s_q.ff_time);
      end
      s_d.hrdata   = rd;
      s_d.hready   = 1'b1;
      s_d.dp_valid = 1'b0;
    end

    // buffer write after any pop so a full buffer always loses its oldest
    if (frame && s_q.mode != MODE_MOTION && s_q.buf_en)
    begin
      mem_we    = 1'b1;
      mem_wdata = {s_d.acc[0], s_d.acc[1], s_d.acc[2]};
      s_d.wptr  = s_q.wptr + 1'b1;
      if (s_d.cnt == LVL_FULL)
      begin
        s_d.rptr = s_d.rptr + 1'b1;
        s_d.axis = 2'h0;
      end
      else
      begin
        s_d.cnt = s_d.cnt + 1'b1;
      end
    end
    if (s_q.mode == MODE_MOTION)
    begin
      s_d.acc = s_q.acc;
    end

    s_d.intsrc[SRC_BUF] = s_d.buf_en &&
                          (s_d.cnt >= (s_d.buf_th ? LVL_3Q : LVL_HALF));
    s_d.irq = |(s_q.intsrc & s_q.intmask);

    if (hsel && htrans[1] && hready)
    begin
      s_d.dp_valid = 1'b1;
      s_d.dp_write = hwrite;
      s_d.dp_addr  = {haddr[7:2], 2'b00};
      s_d.hready   = hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q         <= '0;
      s_q.st      <= ST_LOAD;
      s_q.ckerr   <= CKERR_RST;
      s_q.gain    <= GAIN_RST;
      s_q.mode    <= MODE_NORMAL;
      s_q.ff_th   <= FF_TH_RST;
      s_q.ff_time <= FF_TIME_RST;
      s_q.hready  <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.hready;
  assign hrdata    = s_q.hrdata;
  assign hresp     = 1'b0;
  assign nvm_addr  = s_q.ld_idx;
  assign osc_trim  = s_q.trim;
  assign int_out   = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence buf_pop_s;
    s_q.dp_valid && !s_q.dp_write && s_q.dp_addr == OFF_BUF_DATA &&
    s_q.cnt != '0 && s_q.axis == 2'h2 && !mem_we;
  endsequence

  sequence load_done_s;
    s_q.st == ST_CHECK && s_q.sum == s_q.chk;
  endsequence

  cksum_clear_a: assert property (load_done_s |=> !s_q.ckerr && s_q.st == ST_RUN)
    else $error("checksum flag not cleared");
  normal_start_a: assert property (s_q.st == ST_CHECK |=> s_q.mode == MODE_NORMAL)
    else $error("not in normal mode after load");
  motion_hold_a: assert property (s_q.mode == MODE_MOTION |=> $stable(s_q.acc))
    else $error("output changed in motion mode");
  int_follow_a: assert property ($rose(s_q.intsrc[SRC_MOT]) && s_q.intmask[SRC_MOT]
                                 |=> int_out)
    else $error("interrupt missing");
  buf_bound_a: assert property (s_q.cnt <= LVL_FULL)
    else $error("buffer count over depth");
  pop_order_a: assert property (buf_pop_s |=> s_q.rptr == $past(s_q.rptr) + 1'b1
                                and s_q.axis == 2'h0)
    else $error("read pointer did not advance");
  overwrite_a: assert property (mem_we && s_q.cnt == LVL_FULL && !s_q.dp_valid
                                |=> s_q.cnt == LVL_FULL
                                && s_q.rptr == $past(s_q.rptr) + 1'b1)
    else $error("full buffer did not drop oldest");
  level_src_a: assert property (s_q.buf_en && !s_q.buf_th && s_q.cnt >= LVL_HALF
                                && s_q.intmask[SRC_BUF] |=> int_out)
    else $error("fill level interrupt missing");
  read_wait_a: assert property (s_q.dp_valid && !s_q.dp_write |-> !hreadyout
                                ##1 hreadyout)
    else $error("read data phase length wrong");
endmodule
`default_nettype wire

// [test/acm_nvm_model.sv]
`timescale 1ns/1ps
`default_nettype none
module acm_nvm_model (
  input  wire logic        hclk,
  input  wire logic [1:0]  nvm_addr,
  input  wire logic [15:0] trim,
  input  wire logic        bad_sum,
  output var  logic [15:0] nvm_rdata
);
  import acm_pkg::*;
  logic [15:0] word;

  ////////////////////////////////////////////////////////////////////////////
  // bad_sum spoils the stored checksum so the error path can be seen
  always_comb
  begin
    case (nvm_addr)
      2'h0: word = GAIN_RST;
      2'h1: word = 16'h0000;
      2'h2: word = trim;
      default: word = GAIN_RST + trim + {15'h0000, bad_sum};
    endcase
  end

  // registered read: a word follows its address one cycle later
  always_ff @(posedge hclk)
  begin
    nvm_rdata <= word;
  end
endmodule
`default_nettype wire

// [test/test_accel_sensor_mode_control.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module test_accel_sensor_mode_control;
  import acm_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        adc_valid = 1'b0;
  logic [1:0]  adc_chan = 2'h0;
  logic [15:0] adc_data = 16'h0000;
  logic [8:0]  temp_raw = 9'h000;
  logic [8:0]  tv;
  logic [1:0]  nvm_addr;
  logic [15:0] nvm_rdata;
  logic [15:0] osc_trim;
  logic        int_out;
  logic [15:0] trim;
  logic        bad_sum = 1'b1;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          seed = 32'h0000_b25c;
  int          c0;
  int          c1;
  int          c2;
  int          k;

  always #2.5 hclk = ~hclk;
  assign hready = hreadyout;

  ////////////////////////////////////////////////////////////////////////////
  // lowest-range build: option 1 bypasses the filter, so buffered data is exact;
  // decimation of 1 keeps the run short
  acm_core #(
    .BUF_DEPTH  (64),
    .VARIANT    (0),
    .TEMP_EN    (1'b1),
    .DEC_NORMAL (1)
  ) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .adc_valid(adc_valid),
    .adc_chan(adc_chan), .adc_data(adc_data), .temp_raw(temp_raw), .nvm_addr(nvm_addr),
    .nvm_rdata(nvm_rdata), .osc_trim(osc_trim), .int_out(int_out)
  );

  acm_nvm_model nvm (
    .hclk(hclk), .nvm_addr(nvm_addr), .trim(trim), .bad_sum(bad_sum),
    .nvm_rdata(nvm_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one single word transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    `CHK(rd & m, e)
  endtask

  task automatic frames(input int n, input int a, input int b, input int c);
    repeat (n)
    begin
      for (int ch = 0; ch < 3; ch++)
      begin
        @(posedge hclk);
        adc_valid <= 1'b1;
        adc_chan <= ch[1:0];
        adc_data <= (ch == 0) ? a[15:0] : (ch == 1) ? b[15:0] : c[15:0];
      end
      @(posedge hclk);
      adc_valid <= 1'b0;
    end
  endtask

  // unit gain and zero offset, so an axis is the mapped channel value
  function automatic int axv(input int k, input int a, input int b, input int c);
    return k == 0 ? (a - b) / 2 : k == 1 ? (a + b) / 2 : c;
  endfunction

  // filtered outputs settle only to within a few counts
  function automatic logic near(input logic [31:0] g, input int e);
    int d;
    // an unknown read must not slip through as a near-zero value
    if ($isunknown(g[15:0]))
      return 1'bx;
    d = int'($signed(g[15:0])) - e;
    return d < 16 && d > -16;
  endfunction

  task automatic axes(input int a, input int b, input int c);
    for (int i = 0; i < 3; i++)
    begin
      ahb(1'b0, OFF_X + 8'(4 * i), 32'h0000_0000);
      `CHK(near(rd, axv(i, a, b, c)), 1'b1)
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    trim = 16'($random(seed));
    repeat (8) @(posedge hclk);
    `CHK(hreadyout, 1'b1)
    `CHK(int_out, 1'b0)
    `CHK(osc_trim, 16'h0000)
    hresetn <= 1'b1;
    repeat (20) @(posedge hclk);
    rchk(OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
    hresetn <= 1'b0;
    bad_sum <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (20) @(posedge hclk);
    rchk(OFF_STATUS, 32'h0000_0003, 32'h0000_0002);
    `CHK(osc_trim, trim)
    `CHK(nvm_addr, 2'h0)
    tv = 9'($random(seed));
    temp_raw <= tv;
    rchk(OFF_TEMP, 32'h0000_01ff, {23'h00_0000, tv});
    ahb(1'b1, 8'h3c, 32'hffff_ffff);
    rchk(8'h3c, 32'hffff_ffff, 32'h0000_0000);
    for (int m = 0; m < 3; m++)
    begin
      c0 = 2 * ($random(seed) % 1000);
      c1 = 2 * ($random(seed) % 1000);
      c2 = $random(seed) % 3000;
      ahb(1'b1, OFF_MODE, 32'(m));
      frames(40, c0, c1, c2);
      axes(c0, c1, c2);
    end
    ahb(1'b1, OFF_MOT_CTRL, 32'h0000_0001);
    ahb(1'b1, OFF_MOT_TH, 32'h0000_0001);
    ahb(1'b1, OFF_INT_MASK, 32'h0000_0001);
    ahb(1'b1, OFF_MODE, {29'h0000_0000, MODE_MOTION});
    frames(8, 0, 0, 0);
    frames(2, 4000, 0, 0);
    axes(c0, c1, c2);
    `CHK(int_out, 1'b1)
    rchk(OFF_INT_STAT, 32'h0000_0011, 32'h0000_0011);
    ahb(1'b1, OFF_INT_MASK, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    `CHK(int_out, 1'b0)
    ahb(1'b1, OFF_MODE, 32'(1 << BIT_FF_EN));
    ahb(1'b1, OFF_FF_CFG, 32'h0000_0208);
    ahb(1'b1, OFF_INT_MASK, 32'h0000_0002);
    frames(30, 200, 0, 100);
    `CHK(int_out, 1'b1)
    axes(200, 0, 100);
    rchk(OFF_INT_STAT, 32'h0000_0002, 32'h0000_0002);
    // bypass keeps buffered values exact: x = y = k, z = k + 7
    ahb(1'b1, OFF_MODE, {29'h0000_0000, MODE_OPT1});
    ahb(1'b1, OFF_INT_MASK, 32'h0000_0004);
    ahb(1'b1, OFF_BUF_CTRL, 32'h0000_0001);
    for (k = 0; k < 66; k++)
    begin
      frames(1, 2 * k, 0, k + 7);
      if (k == 30 || k == 31)
      begin
        repeat (8) @(posedge hclk);
        `CHK(int_out, 1'(k == 31))
      end
      if (k == 31)
        ahb(1'b1, OFF_BUF_CTRL, 32'h0000_0003);
    end
    rchk(OFF_BUF_CNT, 32'h0000_00ff, 32'h0000_0040);
    `CHK(int_out, 1'b1)
    for (k = 2; k < 19; k++)
    begin
      rchk(OFF_BUF_DATA, 32'h0000_ffff, 32'(k));
      rchk(OFF_BUF_DATA, 32'h0000_ffff, 32'(k));
      rchk(OFF_BUF_DATA, 32'h0000_ffff, 32'(k + 7));
    end
    repeat (8) @(posedge hclk);
    `CHK(int_out, 1'b0)
    frames(1, 400, 0, 300);
    repeat (8) @(posedge hclk);
    `CHK(int_out, 1'b1)
    rchk(OFF_BUF_DATA, 32'h0000_ffff, 32'h0000_0013);
    rchk(OFF_BUF_CNT, 32'h0000_00ff, 32'h0000_0030);
    print_verdict();
  end

  // the whole sequence needs under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
